/* File: core/ubcm_defines.svh */
// register offsets, field positions and constants of the break matcher
// assumes an APB slave decode of paddr[7:0]
`ifndef UBCM_DEFINES_SVH
`define UBCM_DEFINES_SVH

// register byte offsets
`define UBCM_OFF_BAR_A  8'h00
`define UBCM_OFF_BAM_A  8'h04
`define UBCM_OFF_BBR_A  8'h08
`define UBCM_OFF_BAR_B  8'h0C
`define UBCM_OFF_BAM_B  8'h10
`define UBCM_OFF_BDR_B  8'h14
`define UBCM_OFF_BDM_B  8'h18
`define UBCM_OFF_BBR_B  8'h1C
`define UBCM_OFF_CTRL   8'h20

// control register bits
`define UBCM_B_CFCA  15
`define UBCM_B_CFPA  14
`define UBCM_B_EXT_BUS_BREAK_ENABLE  13
`define UBCM_B_CHAN_A_AFTER_EXEC_SEL  10
`define UBCM_B_CFCB  7
`define UBCM_B_CFPB  6
`define UBCM_B_DBEB  3
`define UBCM_B_CHAN_B_AFTER_EXEC_SEL  2
`define UBCM_CTRL_WMASK 16'hE4CC

// cycle select fields
`define UBCM_F_CP  7:6
`define UBCM_F_ID  5:4
`define UBCM_F_RW  3:2
`define UBCM_F_SZ  1:0
`define UBCM_SEL_WMASK 16'h00FF

// reset values and compare constants
`define UBCM_RST32  32'h0000_0000
`define UBCM_RST16  16'h0000
`define UBCM_LOW_L  32'h0000_0003
`define UBCM_LOW_W  32'h0000_0001
`define UBCM_LOW_B  32'h0000_0000
`define UBCM_EXT_PAD 5'h00
`define UBCM_LEVEL  4'hF
`define UBCM_MASK_MAX 4'hE

`endif

/* File: core/ubcm_pkg.sv */
// types shared by the break matcher
// assumes the defines header for all numbers
package ubcm_pkg;
  // operand size of a cycle select or a bus access
  typedef enum logic [1:0] {
    ubcm_sz_none,
    ubcm_sz_byte,
    ubcm_sz_word,
    ubcm_sz_long
  } ubcm_size_t;
  typedef logic [1:0] ubcm_grp_t;
endpackage

/* File: core/ubcm_matcher.sv */
// two-channel user break condition matcher with APB registers
// assumes a core commit stream, a cpu data stream and external pins
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "ubcm_defines.svh"

module ubcm_matcher
  import ubcm_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        insn_valid,
  input  wire logic [31:0] insn_addr,
  input  wire logic        insn_int_ok,
  input  wire logic [3:0]  sr_imask,
  input  wire logic        dacc_valid,
  input  wire logic [31:0] dacc_addr,
  input  wire logic        dacc_write,
  input  wire ubcm_size_t  dacc_size,
  input  wire logic [31:0] dacc_data,
  input  wire logic        dacc_dummy,
  input  wire logic        bus_released,
  input  wire logic        ext_mode_ok,
  input  wire logic        ext_strobe_pin,
  input  wire logic [26:0] ext_addr_pin,
  input  wire logic        ext_write_pin,
  output logic             user_break_req,
  output logic      [3:0]  user_break_level,
  output logic             break_take,
  output logic      [31:0] break_pc
);

  ////////////////////////////////////////////////////////////////////
  // registers

  logic [31:0] bar_reg [2];
  logic [31:0] bam_reg [2];
  logic [15:0] bbr_reg [2];
  logic [31:0] bdr_reg;
  logic [31:0] bdm_reg;
  logic [15:0] ctrl_reg;
  logic [15:0] ctrl_next;
  logic [31:0] prdata_reg;
  logic [31:0] rd_mux;
  logic        rd_hit;
  logic        pend_reg;
  logic        pend_next;
  logic [31:0] pc_reg;

  // pipeline for pins: strobe, direction, address
  logic [28:0] pin_s1;
  logic [28:0] pin_s2;
  logic [28:0] pin_s3;
  logic        strobe_filt_reg;
  logic        ext_rise;
  logic        ext_ev;

  logic        wr_en;
  logic        setup;
  logic        mask_ok;
  logic        accept;

  // per-channel results
  logic [1:0]  fetch_hit;
  logic [1:0]  before_hit;
  logic [1:0]  after_hit;
  logic [1:0]  data_hit;
  logic [1:0]  ext_hit;
  logic [1:0]  after_sel;

  ////////////////////////////////////////////////////////////////////
  // compare helpers

  // masked address compare, low bits dropped by size
  function automatic logic addr_eq(
    input logic [31:0] bar,
    input logic [31:0] bam,
    input logic [31:0] a,
    input logic [31:0] low
  );
    logic [31:0] care;
    care = ~bam & ~low;
    addr_eq = ((bar ^ a) & care) == `UBCM_RST32;
  endfunction

  // low address bits ignored for each access size
  function automatic logic [31:0] low_of(input ubcm_size_t s);
    logic [31:0] l;
    l = `UBCM_LOW_B;
    unique case (s)
      ubcm_sz_long: l = `UBCM_LOW_L;
      ubcm_sz_word: l = `UBCM_LOW_W;
      ubcm_sz_byte: l = `UBCM_LOW_B;
      ubcm_sz_none: l = `UBCM_LOW_B;
    endcase
    low_of = l;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states

  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite & rd_hit;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~rd_hit;
  assign prdata = prdata_reg;

  // read decode, unmapped reads give zero
  always_comb
  begin
    rd_hit = 1'b1;
    rd_mux = `UBCM_RST32;
    unique case (paddr)
      `UBCM_OFF_BAR_A: rd_mux = bar_reg[0];
      `UBCM_OFF_BAM_A: rd_mux = bam_reg[0];
      `UBCM_OFF_BBR_A: rd_mux = {16'h0000, bbr_reg[0]};
      `UBCM_OFF_BAR_B: rd_mux = bar_reg[1];
      `UBCM_OFF_BAM_B: rd_mux = bam_reg[1];
      `UBCM_OFF_BDR_B: rd_mux = bdr_reg;
      `UBCM_OFF_BDM_B: rd_mux = bdm_reg;
      `UBCM_OFF_BBR_B: rd_mux = {16'h0000, bbr_reg[1]};
      `UBCM_OFF_CTRL:  rd_mux = {16'h0000, ctrl_reg};
      default:         rd_hit = 1'b0;
    endcase
  end

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_reg <= `UBCM_RST32;
    else if (setup)
      prdata_reg <= rd_mux;
  end

  // channel B data value and mask
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bdr_reg <= `UBCM_RST32;
      bdm_reg <= `UBCM_RST32;
    end
    else if (wr_en)
    begin
      if (paddr == `UBCM_OFF_BDR_B)
        bdr_reg <= pwdata;
      if (paddr == `UBCM_OFF_BDM_B)
        bdm_reg <= pwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // control register with sticky flags

  always_comb
  begin
    ctrl_next = ctrl_reg;
    if (wr_en && paddr == `UBCM_OFF_CTRL)
    begin
      ctrl_next = pwdata[15:0] & `UBCM_CTRL_WMASK;
      // flags only clear when written zero
      ctrl_next[`UBCM_B_CFCA] = ctrl_reg[`UBCM_B_CFCA] & pwdata[`UBCM_B_CFCA];
      ctrl_next[`UBCM_B_CFPA] = ctrl_reg[`UBCM_B_CFPA] & pwdata[`UBCM_B_CFPA];
      ctrl_next[`UBCM_B_CFCB] = ctrl_reg[`UBCM_B_CFCB] & pwdata[`UBCM_B_CFCB];
      ctrl_next[`UBCM_B_CFPB] = ctrl_reg[`UBCM_B_CFPB] & pwdata[`UBCM_B_CFPB];
    end
    // a new match wins over a clear
    if (fetch_hit[0] | data_hit[0])
      ctrl_next[`UBCM_B_CFCA] = 1'b1;
    if (fetch_hit[1] | data_hit[1])
      ctrl_next[`UBCM_B_CFCB] = 1'b1;
    if (ext_hit[0])
      ctrl_next[`UBCM_B_CFPA] = 1'b1;
    if (ext_hit[1])
      ctrl_next[`UBCM_B_CFPB] = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_reg <= `UBCM_RST16;
    else
      ctrl_reg <= ctrl_next;
  end

  assign after_sel[0] = ctrl_reg[`UBCM_B_CHAN_A_AFTER_EXEC_SEL];
  assign after_sel[1] = ctrl_reg[`UBCM_B_CHAN_B_AFTER_EXEC_SEL];

  ////////////////////////////////////////////////////////////////////
  // external bus pins, three-stage sampling

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_s1 <= 29'h0000_0000;
      pin_s2 <= 29'h0000_0000;
      pin_s3 <= 29'h0000_0000;
    end
    else
    begin
      pin_s1 <= {ext_strobe_pin, ext_write_pin, ext_addr_pin};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // strobe level counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      strobe_filt_reg <= 1'b0;
    else if (pin_s2[28] == pin_s3[28])
      strobe_filt_reg <= pin_s3[28];
  end

  assign ext_rise = ~strobe_filt_reg & pin_s2[28] & pin_s3[28];
  // watched only when enabled, bus released and mode allows
  assign ext_ev = ext_rise & ctrl_reg[`UBCM_B_EXT_BUS_BREAK_ENABLE]
                & bus_released & ext_mode_ok;

  ////////////////////////////////////////////////////////////////////
  // per-channel registers and matching

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_ch
      logic [7:0] ob;
      logic [7:0] om;
      logic [7:0] oc;
      ubcm_grp_t  cp;
      ubcm_grp_t  id;
      ubcm_grp_t  rw;
      ubcm_size_t sz;
      logic       en;
      logic       sz_ok;
      logic       d_ok;
      logic [31:0] ext_a;

      assign ob = (ch == 0) ? `UBCM_OFF_BAR_A : `UBCM_OFF_BAR_B;
      assign om = (ch == 0) ? `UBCM_OFF_BAM_A : `UBCM_OFF_BAM_B;
      assign oc = (ch == 0) ? `UBCM_OFF_BBR_A : `UBCM_OFF_BBR_B;

      // address, mask and cycle select of this channel
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          bar_reg[ch] <= `UBCM_RST32;
          bam_reg[ch] <= `UBCM_RST32;
          bbr_reg[ch] <= `UBCM_RST16;
        end
        else if (wr_en)
        begin
          if (paddr == ob)
            bar_reg[ch] <= pwdata;
          if (paddr == om)
            bam_reg[ch] <= pwdata;
          if (paddr == oc)
            bbr_reg[ch] <= pwdata[15:0] & `UBCM_SEL_WMASK;
        end
      end

      assign cp = bbr_reg[ch][`UBCM_F_CP];
      assign id = bbr_reg[ch][`UBCM_F_ID];
      assign rw = bbr_reg[ch][`UBCM_F_RW];
      assign sz = ubcm_size_t'(bbr_reg[ch][`UBCM_F_SZ]);

      // a cp, id or rw group at 00 disables the channel; sz at 00 allows any size
      assign en = (|cp) & (|id) & (|rw);

      // fetch: cpu, fetch, read; each instruction address on its own
      assign fetch_hit[ch] = en & cp[0] & id[0] & rw[0] & insn_valid
                           & addr_eq(bar_reg[ch], bam_reg[ch], insn_addr,
                                     `UBCM_LOW_W);
      assign before_hit[ch] = fetch_hit[ch] & ~after_sel[ch];
      assign after_hit[ch]  = fetch_hit[ch] & after_sel[ch];

      // size filter; data compare only on channel B
      assign sz_ok = (sz == ubcm_sz_none) | (sz == dacc_size);
      if (ch == 1)
      begin : g_data
        always_comb
        begin
          d_ok = 1'b1;
          if (ctrl_reg[`UBCM_B_DBEB])
          begin
            if (dacc_size == ubcm_sz_long)
              d_ok = ((bdr_reg ^ dacc_data) & ~bdm_reg) == `UBCM_RST32;
            else
              d_ok = ((bdr_reg[15:0] ^ dacc_data[15:0])
                     & ~bdm_reg[15:0]) == `UBCM_RST16;
          end
        end
      end
      else
      begin : g_nodata
        assign d_ok = 1'b1;
      end

      // cpu data access, dummy dram reads excluded
      assign data_hit[ch] = en & cp[0] & id[1] & dacc_valid & ~dacc_dummy
                          & (dacc_write ? rw[1] : rw[0]) & sz_ok
                          & addr_eq(bar_reg[ch], bam_reg[ch], dacc_addr,
                                    low_of(dacc_size))
                          & d_ok;

      // external cycle: 27 lines, address and direction only
      assign ext_a = {`UBCM_EXT_PAD, pin_s3[26:0]};
      assign ext_hit[ch] = en & cp[1] & id[1] & ext_ev
                         & (pin_s3[27] ? rw[1] : rw[0])
                         & addr_eq(bar_reg[ch], bam_reg[ch], ext_a, `UBCM_LOW_B);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // break request and taking

  // level 15 passes only under mask 14 or lower
  assign mask_ok = sr_imask <= `UBCM_MASK_MAX;
  assign accept  = insn_valid & insn_int_ok & mask_ok;
  assign break_take = accept & (pend_reg | (|before_hit));

  // pending held until an accepting instruction boundary
  always_comb
  begin
    pend_next = (pend_reg | (|before_hit)) & ~break_take;
    if (|data_hit | |ext_hit)
      pend_next = 1'b1;
    if ((|after_hit) & ~break_take)
      pend_next = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pend_reg <= 1'b0;
    else
      pend_reg <= pend_next;
  end

  // stacked pc is the instruction where the break is taken
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pc_reg <= `UBCM_RST32;
    else if (break_take)
      pc_reg <= insn_addr;
  end

  assign break_pc = pc_reg;
  assign user_break_req = pend_reg;
  assign user_break_level = `UBCM_LEVEL;

endmodule

/* File: sim/ubcm_monitor.sv */
// concurrent checks on the break matcher top ports
// assumes one clock domain, pclk with async active-low presetn
`timescale 1ns/1ps
module ubcm_monitor
  import ubcm_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic        pslverr,
  input wire logic        insn_valid,
  input wire logic [31:0] insn_addr,
  input wire logic        insn_int_ok,
  input wire logic [3:0]  sr_imask,
  input wire logic        user_break_req,
  input wire logic [3:0]  user_break_level,
  input wire logic        break_take,
  input wire logic [31:0] break_pc
);
  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // request level and acceptance
  a_level_fixed: assert property (user_break_level == 4'hF)
    else $error("break level is not fifteen");
  a_take_on_insn: assert property (break_take |-> insn_valid)
    else $error("break taken without a committed instruction");
  a_take_accept: assert property (break_take |-> insn_int_ok && sr_imask <= 4'hE)
    else $error("break taken where interrupts are refused");
  a_pending_take: assert property
    (user_break_req && insn_valid && insn_int_ok && sr_imask <= 4'hE |-> break_take)
    else $error("pending break not taken at accepting instruction");
  a_req_pending: assert property (user_break_req && !break_take |=> user_break_req)
    else $error("pending break request dropped");
  // stacked program counter and unmapped access error
  a_take_pc: assert property (break_take |=> break_pc == $past(insn_addr))
    else $error("stacked pc differs from taking instruction");
  a_pc_hold: assert property (!break_take |=> $stable(break_pc))
    else $error("stacked pc changed without a break");
  a_err_unmapped: assert property (psel && penable && paddr > 8'h20 |-> pslverr)
    else $error("unmapped access without slave error");
  c_take: cover property (break_take);
  c_req: cover property ($rose(user_break_req));
  c_err: cover property (pslverr);
endmodule

bind ubcm_matcher ubcm_monitor ubcm_monitor_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .pslverr(pslverr), .insn_valid(insn_valid),
  .insn_addr(insn_addr), .insn_int_ok(insn_int_ok), .sr_imask(sr_imask),
  .user_break_req(user_break_req), .user_break_level(user_break_level),
  .break_take(break_take), .break_pc(break_pc));

/* File: sim/ubcm_ext_master.sv */
// external bus master that drives cycles while the bus is released
// assumes the bench calls cycle() and holds bus_released meanwhile
`timescale 1ns/1ps
module ubcm_ext_master (
  input  wire logic        pclk,
  output logic             ext_strobe_pin,
  output logic      [26:0] ext_addr_pin,
  output logic             ext_write_pin
);
  ////////////////////////////////////////////////////////////////////
  initial
  begin
    ext_strobe_pin = 1'b0;
    ext_addr_pin = 27'h0000000;
    ext_write_pin = 1'b0;
  end
  // one cycle on 27 lines; no size is signalled, address and direction only
  task automatic cycle(input logic [26:0] a, input logic w);
    @(posedge pclk);
    ext_strobe_pin <= 1'b1;
    ext_addr_pin <= a;
    ext_write_pin <= w;
    repeat (6) @(posedge pclk);
    ext_strobe_pin <= 1'b0;
    ext_addr_pin <= ~a; // released lines never hold the old value
    ext_write_pin <= ~w;
  endtask
endmodule

/* File: sim/tb.sv */
// self-checking bench for the break matcher
// assumes zero-wait apb and the ext master model beside the design
`timescale 1ns/1ps
module tb;
  import ubcm_pkg::*;
  typedef struct packed {
    logic [7:0] sel; logic [15:0] ctl; ubcm_size_t sz;
    logic [31:0] addr; logic [31:0] data; logic dummy; logic hit;
  } ubcm_row_t;
  // channel B data rows: address width, dummy, data, disabled group, mask
  localparam ubcm_row_t ROWS [0:9] = '{
    '{8'h64, 16'h0000, ubcm_sz_long, 32'h1000, 32'h0, 1'b0, 1'b1},
    '{8'h64, 16'h0000, ubcm_sz_word, 32'h1002, 32'h0, 1'b0, 1'b1},
    '{8'h64, 16'h0000, ubcm_sz_byte, 32'h1003, 32'h0, 1'b0, 1'b1},
    '{8'h64, 16'h0000, ubcm_sz_byte, 32'h1002, 32'h0, 1'b0, 1'b0},
    '{8'h64, 16'h0000, ubcm_sz_long, 32'h1004, 32'h0, 1'b0, 1'b0},
    '{8'h64, 16'h0000, ubcm_sz_byte, 32'h1003, 32'h0, 1'b1, 1'b0},
    '{8'h66, 16'h0008, ubcm_sz_word, 32'h1002, 32'hFFFF5A5A, 1'b0, 1'b1},
    '{8'h66, 16'h0008, ubcm_sz_word, 32'h1002, 32'h00005A5B, 1'b0, 1'b0},
    '{8'h24, 16'h0000, ubcm_sz_byte, 32'h1003, 32'h0, 1'b0, 1'b0},
    '{8'h64, 16'h0000, ubcm_sz_long, 32'h1F00, 32'h0, 1'b0, 1'b1}};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, t;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r, pc, insn_addr, dacc_addr, dacc_data, break_pc;
  logic insn_valid, insn_int_ok, dacc_valid, dacc_dummy, bus_released, ext_mode_ok;
  logic dacc_write;
  logic ext_strobe_pin, ext_write_pin, user_break_req, break_take;
  logic [3:0] sr_imask, user_break_level;
  logic [26:0] ext_addr_pin;
  ubcm_size_t dacc_size;
  int failures = 0;
  int comparisons = 0;
  ////////////////////////////////////////////////////////////////////
  ubcm_matcher ubcm_matcher_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .insn_valid(insn_valid), .insn_addr(insn_addr),
    .insn_int_ok(insn_int_ok), .sr_imask(sr_imask), .dacc_valid(dacc_valid),
    .dacc_addr(dacc_addr), .dacc_write(dacc_write), .dacc_size(dacc_size),
    .dacc_data(dacc_data),
    .dacc_dummy(dacc_dummy), .bus_released(bus_released), .ext_mode_ok(ext_mode_ok),
    .ext_strobe_pin(ext_strobe_pin), .ext_addr_pin(ext_addr_pin),
    .ext_write_pin(ext_write_pin), .user_break_req(user_break_req),
    .user_break_level(user_break_level), .break_take(break_take), .break_pc(break_pc));
  ubcm_ext_master ubcm_ext_master_i (.pclk(pclk), .ext_strobe_pin(ext_strobe_pin),
    .ext_addr_pin(ext_addr_pin), .ext_write_pin(ext_write_pin));
  ////////////////////////////////////////////////////////////////////
  // clock generation
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task chk(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1)
    begin
      failures++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task give_verdict;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // apb transfer, held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for the answer; only the watchdog ends a hang
    do
    begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task dacc(input ubcm_row_t w);
    @(posedge pclk);
    dacc_valid <= 1'b1;
    dacc_addr <= w.addr;
    dacc_size <= w.sz;
    dacc_data <= w.data;
    dacc_dummy <= w.dummy;
    sr_imask <= 4'hF;
    @(posedge pclk);
    dacc_valid <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  // committed instruction; take sampled mid-cycle, pc after the edge
  task insn(input logic [31:0] a, input logic ok, input logic [3:0] m);
    @(posedge pclk);
    insn_valid <= 1'b1;
    insn_addr <= a;
    insn_int_ok <= ok;
    sr_imask <= m;
    @(negedge pclk);
    t = break_take;
    @(posedge pclk);
    insn_valid <= 1'b0;
    #1 pc = break_pc;
  endtask
  // watchdog
  initial
  begin
    #200000;
    failures++;
    give_verdict();
  end
  // main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, insn_valid, insn_addr} = '0;
    {insn_int_ok, sr_imask, dacc_valid, dacc_addr, dacc_data, dacc_dummy} = '0;
    {bus_released, ext_mode_ok, dacc_write} = '0;
    dacc_size = ubcm_sz_none;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h20, 32'h0);
    chk(r === 32'h0 && user_break_req === 1'b0, "control not clear after reset");
    apb(1'b0, 8'h24, 32'h0);
    chk(r === 32'h0 && e === 1'b1, "unmapped read not refused");
    apb(1'b1, 8'h0C, 32'h1003);
    apb(1'b1, 8'h10, 32'h0F00);
    apb(1'b1, 8'h14, 32'h5A5A);
    foreach (ROWS[i])
    begin
      apb(1'b1, 8'h1C, {24'h0, ROWS[i].sel});
      apb(1'b1, 8'h20, {16'h0, ROWS[i].ctl});
      dacc(ROWS[i]);
      apb(1'b0, 8'h20, 32'h0);
      chk(r[7] === ROWS[i].hit, "data row flag wrong");
    end
    // cpu write against a read condition, then against a write condition
    dacc_write <= 1'b1;
    apb(1'b1, 8'h20, 32'h0);
    dacc(ROWS[0]);
    apb(1'b0, 8'h20, 32'h0);
    chk(r[7] === 1'b0, "cpu write matched a read condition");
    apb(1'b1, 8'h1C, 32'h68);
    dacc(ROWS[0]);
    apb(1'b0, 8'h20, 32'h0);
    chk(r[7] === 1'b1, "cpu write condition missed");
    dacc_write <= 1'b0;
    insn(32'h200, 1'b1, 4'h0);
    chk(t === 1'b1 && pc === 32'h200, "pending data break not taken");
    apb(1'b1, 8'h00, 32'h404);
    apb(1'b1, 8'h08, 32'h56);
    apb(1'b1, 8'h20, 32'h0);
    insn(32'h404, 1'b1, 4'h0);
    chk(t === 1'b1 && pc === 32'h404, "before break wrong");
    insn(32'h404, 1'b1, 4'hF);
    chk(t === 1'b0 && user_break_req === 1'b1, "break taken under mask 15");
    insn(32'h406, 1'b0, 4'h0);
    chk(t === 1'b0, "break taken at refusing instruction");
    insn(32'h408, 1'b1, 4'h0);
    chk(t === 1'b1 && pc === 32'h408, "deferred break wrong");
    apb(1'b1, 8'h20, 32'h0400);
    insn(32'h404, 1'b1, 4'h0);
    chk(t === 1'b0, "after break taken too early");
    insn(32'h406, 1'b1, 4'h0);
    chk(t === 1'b1 && pc === 32'h406, "after break wrong");
    apb(1'b0, 8'h20, 32'h0);
    chk(r[15] === 1'b1, "cpu flag A not set");
    apb(1'b1, 8'h00, 32'h1234);
    apb(1'b1, 8'h08, 32'hA7);
    apb(1'b1, 8'h20, 32'h2000);
    bus_released <= 1'b1;
    ext_mode_ok <= 1'b1;
    ubcm_ext_master_i.cycle(27'h1234, 1'b1);
    repeat (4) @(posedge pclk);
    apb(1'b0, 8'h20, 32'h0);
    chk(r[14] === 1'b0, "ext write matched a read condition");
    ubcm_ext_master_i.cycle(27'h1234, 1'b0);
    repeat (4) @(posedge pclk);
    apb(1'b0, 8'h20, 32'h0);
    chk(r[14] === 1'b1 && r[15] === 1'b0, "ext hit flag wrong");
    apb(1'b1, 8'h20, 32'h2000);
    apb(1'b0, 8'h20, 32'h0);
    chk(r[14] === 1'b0, "flag not cleared by zero");
    chk(user_break_req === 1'b1, "ext hit left no pending request");
    // reset in mid-run drops the pending request and the stacked pc
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(user_break_req === 1'b0 && break_pc === 32'h0, "reset left break state");
    presetn <= 1'b1;
    apb(1'b0, 8'h20, 32'h0);
    chk(r === 32'h0, "control not clear after second reset");
    give_verdict();
  end
endmodule
